// [design/sci_pkg.sv]
/*
 * Shared constants of the synchronous DRAM command interface: geometry
 * defaults, command encodings, mode word layout, burst state codes.
 * Assumes a single 100 MHz system clock; no timing counts are enforced here.
 */
`default_nettype none

package sci_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // geometry defaults: four banks of 4096 rows by 256 words of 32 bits
   localparam int DEF_BANK_W = 2;
   localparam int DEF_ROW_W = 12;
   localparam int DEF_COL_W = 8;
   localparam int DEF_DATA_W = 32;
   localparam int BUF_DEPTH = 2;

   ////////////////////////////////////////////////////////////////////////////
   // command codes as {row strobe, column strobe, write enable}, all active low
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_BURST_STOP = 3'h6;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_ROW_OPEN = 3'h3;
   localparam logic [2:0] CMD_CLOSE = 3'h2;
   localparam logic [2:0] CMD_REFRESH = 3'h1;
   localparam logic [2:0] CMD_MODE_LOAD = 3'h0;

   // address line that carries the auto close flag and the all banks choice
   localparam int ADDR_AUTO_CLOSE_BIT = 10;

   ////////////////////////////////////////////////////////////////////////////
   // mode word, loaded from the address lines
   localparam int MR_W = 12;
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] CL_2 = 3'h2;
   localparam logic [2:0] CL_3 = 3'h3;
   // burst of one, sequential, latency two
   localparam logic [MR_W-1:0] MR_RESET = 12'h020;

   ////////////////////////////////////////////////////////////////////////////
   // burst engine states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h4
   } sci_burst_e;

endpackage

`default_nettype wire

// [design/sci_buf2.sv]
/*
 * Small first-in first-out buffer with valid and ready on both sides.
 * Assumes the depth is a power of two; storage is not reset, only pointers and count.
 */
`timescale 1ns/1ps
`default_nettype none

module sci_buf2 #(
   parameter int W = 32,
   parameter int DEPTH = sci_pkg::BUF_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   import sci_pkg::*;

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
   localparam logic [PW:0] ONE_CNT = (PW+1)'(1);

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
      $error("sci_buf2: depth must be a power of two, at least two");
   end

   logic [W-1:0] slot_r [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [PW:0] cnt_r;

   ////////////////////////////////////////////////////////////////////////////
   // handshakes; ready looks at the count only, so a full buffer never
   // depends on a same-cycle drain and no combinational path crosses it
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = cnt_r != FULL_CNT;
   assign out_valid_o = cnt_r != '0;
   assign out_data_o = slot_r[rp_r];

   // pointers wrap naturally because the depth is a power of two
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         if (push && !pop) cnt_r <= cnt_r + ONE_CNT;
         else if (pop && !push) cnt_r <= cnt_r - ONE_CNT;
      end
   end

   // storage
   always_ff @(posedge clk_i) begin
      if (push) slot_r[wp_r] <= in_data_i;
   end

endmodule

`default_nettype wire

// [design/sci_sdram.sv]
/*
 * Synchronous DRAM device logic behind its pins: command decode, bank and
 * row tracking, burst engine, memory array, read latency pipe, byte masks.
 * Assumes all pins are synchronous to clk_i and that the controller keeps
 * its own timing (close time, refresh rate, legal command order).
 */
// Notes on behaviour
// - all pins except clock enable are taken on the rising clock edge.
// - four banks, 4096 rows, 256 columns, one 32-bit word per column.
// - bursts last 1, 2, 4, 8 words or a page; burst stop ends early.
// - burst column order is sequential or interleaved, generated internally.
// - read latency is programmable to two or three clocks.
// - row open takes bank from bank_select, row from all address lines.
// - read and write take column from low address lines, in the open row.
// - auto_close_flag high closes the row after the burst; low keeps it.
// - close command with auto_close_flag high closes all banks, else one.
// - edges count only while clock enable is high; low means suspend.
// - chip select high ignores command lines; a running burst still advances.
// - read mask high floats its byte lane two clocks later.
// - write mask high leaves that byte unchanged; low writes it.
// - each of four mask bits governs one byte lane of data_bus.
// - write data is taken on the command edge and following burst edges.
// - mode load takes burst and latency settings from address lines.
// - a new read or write any cycle restarts the burst at its column.
// - one bank may close while another bank is being accessed.
// - command codes from row strobe, column strobe, write enable levels.
`timescale 1ns/1ps
`default_nettype none

module sci_sdram #(
   parameter int BANK_W = sci_pkg::DEF_BANK_W,
   parameter int ROW_W = sci_pkg::DEF_ROW_W,
   parameter int COL_W = sci_pkg::DEF_COL_W,
   parameter int DATA_W = sci_pkg::DEF_DATA_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // command pins
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [BANK_W-1:0] bank_select_i,
   input wire logic [ROW_W-1:0] addr_i,
   // data pins, split into input, output and per-lane enable
   input wire logic [DATA_W/8-1:0] byte_mask_i,
   input wire logic [DATA_W-1:0] data_bus_i,
   output logic [DATA_W-1:0] data_bus_o,
   output logic [DATA_W/8-1:0] data_bus_oe_o,
   // status
   output logic [(1<<BANK_W)-1:0] bank_open_o,
   output logic burst_read_o,
   output logic burst_write_o,
   output logic power_down_o
);
   import sci_pkg::*;

   localparam int NBANK = 1 << BANK_W;
   localparam int NLANE = DATA_W / 8;
   localparam int AW = BANK_W + ROW_W + COL_W;
   localparam logic [COL_W:0] K_ONE = (COL_W+1)'(1);

   if (COL_W < 3 || ROW_W < MR_W || DATA_W % 8 != 0) begin : g_chk
      $error("sci_sdram: geometry not supported");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic cke_prev_r;
   logic [MR_W-1:0] mode_r;
   logic [NBANK-1:0] bank_open_r;
   logic [NBANK-1:0] open_nxt;
   logic [ROW_W-1:0] row_r [NBANK];
   sci_burst_e st_r;
   sci_burst_e st_nxt;
   logic [BANK_W-1:0] bnk_r;
   logic [COL_W-1:0] start_r;
   logic [COL_W:0] k_r;
   logic ap_r;
   logic [NLANE-1:0] mask_q_r;
   logic out_vld_r;
   logic p_vld_r;
   logic [DATA_W-1:0] p_dat_r;
   logic [DATA_W-1:0] mem [1<<AW];

   wire buf_in_rdy;
   wire buf_out_vld;
   wire [DATA_W-1:0] buf_out_dat;

   ////////////////////////////////////////////////////////////////////////////
   // edge qualification: an edge counts when the enable was high before it
   wire en = cke_prev_r;
   // a full buffer stalls the whole engine rather than drop a word
   wire step = en && buf_in_rdy;

   // command decode
   wire [2:0] cmd = {ras_n_i, cas_n_i, we_n_i};
   wire sel = step && !cs_n_i;
   wire is_rd = sel && cmd == CMD_READ;
   wire is_wr = sel && cmd == CMD_WRITE;
   wire is_act = sel && cmd == CMD_ROW_OPEN;
   wire is_pre = sel && cmd == CMD_CLOSE;
   wire is_bst = sel && cmd == CMD_BURST_STOP;
   wire is_mrs = sel && cmd == CMD_MODE_LOAD;
   wire flag = addr_i[ADDR_AUTO_CLOSE_BIT];

   // access to a closed bank starts no burst but still ends a running one; the controller avoids it
   wire bank_ok = bank_open_r[bank_select_i];
   wire rd_go = is_rd && bank_ok;
   wire wr_go = is_wr && bank_ok;
   wire burst_go = rd_go || wr_go;
   wire pre_hit = is_pre && (flag || bank_select_i == bnk_r);
   wire kill = is_rd || is_wr || is_bst || pre_hit;

   ////////////////////////////////////////////////////////////////////////////
   // mode fields
   wire cl3 = mode_r[MR_CL_LSB +: 3] == CL_3;
   wire [2:0] bl_code = mode_r[MR_BL_LSB +: 3];
   wire full_page = bl_code == BL_FULL;
   wire interleave = mode_r[MR_BT_BIT] && !full_page;
   wire [COL_W:0] bl_words = full_page ? {1'b1, {COL_W{1'b0}}} :
                                         ({{COL_W{1'b0}}, 1'b1} << bl_code);
   wire [COL_W:0] bl_m1 = bl_words - 1'b1;
   wire [COL_W-1:0] wrap_m = bl_m1[COL_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // address generation: only the low bits inside the burst window move
   wire active = st_r != ST_IDLE;
   wire cont = step && active && !kill;
   wire [COL_W-1:0] seq_lo = interleave ? (start_r ^ k_r[COL_W-1:0]) :
                                          (start_r + k_r[COL_W-1:0]);
   wire [COL_W-1:0] burst_col = (start_r & ~wrap_m) | (seq_lo & wrap_m);
   wire [BANK_W-1:0] acc_bnk = burst_go ? bank_select_i : bnk_r;
   wire [COL_W-1:0] acc_col = burst_go ? addr_i[COL_W-1:0] : burst_col;
   wire [AW-1:0] acc_addr = {acc_bnk, row_r[acc_bnk], acc_col};
   wire rd_acc = rd_go || (cont && st_r == ST_READ);
   wire wr_acc = wr_go || (cont && st_r == ST_WRITE);
   wire [COL_W:0] k_step = burst_go ? K_ONE : k_r + 1'b1;
   // a full page burst wraps until stopped, so it never reaches its end
   wire last = !full_page && k_step == bl_words;
   wire ap_now = burst_go ? flag : ap_r;
   wire ap_close = (burst_go || cont) && last && ap_now;
   wire [DATA_W-1:0] rd_word = mem[acc_addr];
   wire [7:0] old_byte0 = rd_word[7:0];

   // read words enter the buffer now, or one edge later for latency three
   wire push_vld = cl3 ? (p_vld_r && step) : rd_acc;
   wire [DATA_W-1:0] push_dat = cl3 ? p_dat_r : rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // next bank state; a close and an open of the same bank in one cycle leave it closed
   always_comb begin
      open_nxt = bank_open_r;
      if (is_act) open_nxt[bank_select_i] = 1'b1;
      if (is_pre) begin
         if (flag) open_nxt = '0;
         else open_nxt[bank_select_i] = 1'b0;
      end
      if (ap_close) open_nxt[acc_bnk] = 1'b0;
   end

   // burst engine
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (burst_go && !last) st_nxt = rd_go ? ST_READ : ST_WRITE;
         end
         ST_READ, ST_WRITE: begin
            if (burst_go) st_nxt = last ? ST_IDLE : (rd_go ? ST_READ : ST_WRITE);
            else if (kill || (cont && last)) st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock enable history, mode word, bank flags, burst registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cke_prev_r <= 1'b0;
         mode_r <= MR_RESET;
         bank_open_r <= '0;
         st_r <= ST_IDLE;
      end else begin
         cke_prev_r <= cke_i;
         if (is_mrs) mode_r <= addr_i[MR_W-1:0];
         bank_open_r <= open_nxt;
         if (step) st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bnk_r <= '0;
         start_r <= '0;
         k_r <= '0;
         ap_r <= 1'b0;
      end else if (burst_go) begin
         bnk_r <= bank_select_i;
         start_r <= addr_i[COL_W-1:0];
         k_r <= k_step;
         ap_r <= flag;
      end else if (cont) begin
         k_r <= k_step;
      end
   end

   // open row per bank
   for (genvar b = 0; b < NBANK; b++) begin : g_row
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) row_r[b] <= '0;
         else if (is_act && bank_select_i == BANK_W'(b)) row_r[b] <= addr_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array write, lane by lane, with the mask sampled alongside the data
   always_ff @(posedge clk_i) begin
      if (wr_acc) begin
         for (int l = 0; l < NLANE; l++) begin
            if (!byte_mask_i[l]) mem[acc_addr][8*l +: 8] <= data_bus_i[8*l +: 8];
         end
      end
   end

   // extra latency stage, used only at latency three
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         p_vld_r <= 1'b0;
         p_dat_r <= '0;
      end else if (step) begin
         p_vld_r <= rd_acc;
         p_dat_r <= rd_word;
      end
   end

   // buffer drains on every counted edge; a suspended clock holds it
   sci_buf2 #(
      .W(DATA_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(push_vld),
      .in_ready_o(buf_in_rdy),
      .in_data_i(push_dat),
      .out_valid_o(buf_out_vld),
      .out_ready_i(en),
      .out_data_o(buf_out_dat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output stage: the mask from the edge before gates the lanes, so a mask
   // taken at edge m floats the data sampled at edge m+2
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data_bus_o <= '0;
         data_bus_oe_o <= '0;
         out_vld_r <= 1'b0;
         mask_q_r <= '0;
      end else if (en) begin
         if (buf_out_vld) data_bus_o <= buf_out_dat; // empty slot never leaks out
         data_bus_oe_o <= {NLANE{buf_out_vld}} & ~mask_q_r;
         out_vld_r <= buf_out_vld;
         mask_q_r <= byte_mask_i;
      end
   end

   // status
   assign bank_open_o = bank_open_r;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         burst_read_o <= 1'b0;
         burst_write_o <= 1'b0;
         power_down_o <= 1'b0;
      end else begin
         if (step) burst_read_o <= st_nxt == ST_READ;
         if (step) burst_write_o <= st_nxt == ST_WRITE;
         power_down_o <= !cke_i && bank_open_r == '0 && st_r == ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_rd_cl2;
      rd_go && !cl3 ##1 en;
   endsequence
   sequence s_rd_cl3;
      rd_go && cl3 ##1 en ##1 en;
   endsequence
   sequence s_burst4;
      burst_go && bl_words == 9'd4 ##1 (step && !kill) [*3];
   endsequence

   a_rd_lat_two: assert property (s_rd_cl2 |=> out_vld_r)
      else $error("read word missing at latency two");
   a_rd_lat_three: assert property (s_rd_cl3 |=> out_vld_r)
      else $error("read word missing at latency three");
   a_mask_float: assert property (en && byte_mask_i[0] ##1 en |=> !data_bus_oe_o[0])
      else $error("masked read lane still driven");
   a_cs_hold: assert property (cs_n_i && !active |=> $stable(bank_open_r) && $stable(mode_r))
      else $error("state changed while deselected");
   a_close_all: assert property (is_pre && flag |=> bank_open_r == '0)
      else $error("close all left a bank open");
   a_close_one: assert property (is_pre && !flag && !is_act |=> !bank_open_r[$past(bank_select_i)])
      else $error("selected bank not closed");
   a_row_open: assert property (is_act |=> bank_open_r[$past(bank_select_i)])
      else $error("row open did not open bank");
   a_suspend_hold: assert property (!en |=> $stable(data_bus_o) && $stable(st_r))
      else $error("state moved on a suspended edge");
   a_burst_len: assert property (s_burst4 |=> st_r == ST_IDLE)
      else $error("four word burst did not end");
   a_auto_close: assert property (burst_go && flag && bl_words == 9'd1 && !is_act
                                  |=> !bank_open_r[$past(bank_select_i)])
      else $error("auto close did not close bank");
   a_wr_masked: assert property (wr_acc && byte_mask_i[0]
                                 |=> mem[$past(acc_addr)][7:0] == $past(old_byte0))
      else $error("masked byte was written");
   a_mode_cl: assert property (is_mrs && addr_i[MR_CL_LSB +: 3] == CL_3 |=> cl3)
      else $error("mode load did not set latency");

endmodule

`default_nettype wire

// [testbench/sci_ctl_model.sv]
/*
 * Controller-side model: drives the command pins one command per edge and
 * resolves the split data bus. Assumes the bench calls step at a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sci_ctl_model (
   // clock
   input wire logic clk_i,
   // command pins
   output logic cke_o,
   output logic cs_n_o,
   output logic [2:0] cmd_o,
   output logic [1:0] bank_o,
   output logic [11:0] addr_o,
   output logic [3:0] mask_o,
   // data bus and device status
   input wire logic [31:0] dq_o_i,
   input wire logic [3:0] dq_oe_i,
   output logic [31:0] dq_i_o,
   input wire logic [3:0] open_i,
   input wire logic pd_i,
   input wire logic [1:0] burst_i
);
   logic drv = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] last = 32'h0;
   logic [31:0] s_d;
   logic [3:0] s_oe;
   logic [3:0] s_open;
   logic s_pd;
   logic [1:0] s_burst;

   // quiet pins from time zero
   initial begin
      cke_o = 1'b1;
      cs_n_o = 1'b1;
      cmd_o = 3'h7;
      bank_o = 2'h0;
      addr_o = 12'h0;
      mask_o = 4'h0;
   end

   ////////////////////////////////////////////////////////////
   // a released lane shows the inverse of our last word, so a stale copy never passes
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         dq_i_o[8*l+:8] = dq_oe_i[l] ? dq_o_i[8*l+:8] : (drv ? wd[8*l+:8] : ~last[8*l+:8]);
      end
   end

   always @(posedge clk_i) begin
      if (drv) last <= wd;
   end

   // pins change just after an edge and hold to the next one
   task automatic step(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [3:0] m, input logic [31:0] d, input logic w);
      cs_n_o <= c[3];
      cmd_o <= c[2:0];
      bank_o <= b;
      addr_o <= a;
      mask_o <= m;
      wd <= d;
      drv <= w;  // write words ride the command edge and the burst edges
      @(negedge clk_i);
      s_d = dq_o_i;
      s_oe = dq_oe_i;
      s_open = open_i;
      s_pd = pd_i;
      s_burst = burst_i;
      @(posedge clk_i);
   endtask

   // clock enable only moves beside a command step
   task automatic set_cke(input logic v);
      cke_o <= v;
   endtask
endmodule

`default_nettype wire

// [testbench/sci_sdram_test.sv]
/*
 * Self-checking bench for the dram device logic: command sequences checked
 * against a word model. Assumes a 100 MHz clock and one command per edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sci_sdram_test;
   import sci_pkg::*;
   localparam int CLOSE_WAIT = 2;  // assumed bank_close_time in cycles
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic cke, cs_n, pd, brd, bwr;
   logic [2:0] cpins;
   logic [1:0] bank;
   logic [11:0] addr;
   logic [3:0] mask, oe, open;
   logic [31:0] dq_in, dq_out;
   int mismatches = 0;
   int n_checks = 0;
   logic [31:0] mem [logic [21:0]];
   logic [11:0] row_of [4];
   logic [11:0] mode = MR_RESET;
   logic [3:0] open_e = 4'h0;

   always #5 clk_i = ~clk_i;

   sci_sdram DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .cke_i(cke), .cs_n_i(cs_n),
      .ras_n_i(cpins[2]), .cas_n_i(cpins[1]), .we_n_i(cpins[0]), .bank_select_i(bank),
      .addr_i(addr), .byte_mask_i(mask), .data_bus_i(dq_in), .data_bus_o(dq_out),
      .data_bus_oe_o(oe), .bank_open_o(open), .burst_read_o(brd), .burst_write_o(bwr),
      .power_down_o(pd));
   sci_ctl_model ctl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cpins),
      .bank_o(bank), .addr_o(addr), .mask_o(mask), .dq_o_i(dq_out), .dq_oe_i(oe),
      .dq_i_o(dq_in), .open_i(open), .pd_i(pd), .burst_i({brd, bwr}));

   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
      ctl.step({1'b0, c}, b, a, 4'h0, 32'h0, 1'b0);
   endtask

   // column of burst word k under the current mode
   function automatic logic [7:0] col_at(input logic [7:0] s, input int k);
      logic [7:0] w;
      w = (mode[2:0] == BL_FULL) ? 8'hff : 8'((1 << mode[2:0]) - 1);
      if (mode[MR_BT_BIT] && mode[2:0] != BL_FULL) return s ^ 8'(k);
      return (s & ~w) | (8'(s + k) & w);
   endfunction

   // a row is always opened before its bank is touched
   task automatic open_row(input logic [1:0] b, input logic [11:0] r);
      cmd(CMD_ROW_OPEN, b, r);
      row_of[b] = r;
      open_e[b] = 1'b1;
   endtask

   task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic ac, input int n,
                     input logic [31:0] d0, input logic [3:0] m);
      logic [31:0] d;
      logic [7:0] col;
      for (int k = 0; k < n; k++) begin
         d = d0 + 32'(k);
         col = col_at(c, k);
         if (k == 0) ctl.step({1'b0, CMD_WRITE}, b, {1'b0, ac, 2'h0, c}, m, d, 1'b1);
         else ctl.step({1'b0, CMD_NOP}, b, 12'h0, m, d, 1'b1);
         if (k > 0) chk("wr_burst", {30'h0, ctl.s_burst}, 32'h1);
         for (int l = 0; l < 4; l++)
            if (!m[l]) mem[{b, row_of[b], col}][8*l+:8] = d[8*l+:8];
      end
   endtask

   // read burst of n words; command xc replaces the nop at step xi
   task automatic rd(input logic [1:0] b, input logic [7:0] c, input int n, input logic [3:0] m,
                     input int xi, input logic [2:0] xc, input logic [1:0] xb);
      int cl;
      cl = (mode[6:4] == CL_3) ? 3 : 2;
      ctl.step({1'b0, CMD_READ}, b, {4'h0, c}, m, 32'h0, 1'b0);
      for (int i = 1; i <= cl + n; i++) begin
         if (i == xi) cmd(xc, xb, 12'h0);
         else cmd(CMD_NOP, 2'h0, 12'h0);
         if (i == 1) chk("rd_burst", {30'h0, ctl.s_burst}, (n > 1) ? 32'h2 : 32'h0);
         if (i >= cl && i < cl + n) begin
            chk("rd_oe", {28'h0, ctl.s_oe}, (i == cl && cl == 2) ? {28'h0, ~m} : 32'hf);
            if (i > cl || m == 4'h0)
               chk("rd_data", ctl.s_d, mem[{b, row_of[b], col_at(c, i - cl)}]);
         end
      end
      chk("rd_end", {28'h0, ctl.s_oe}, 32'h0);
   endtask

   // every bank idle before a mode load, then open rows come back
   task automatic set_mode(input logic [11:0] w);
      cmd(CMD_CLOSE, 2'h0, 12'h400);
      repeat (CLOSE_WAIT) cmd(CMD_NOP, 2'h0, 12'h0);
      chk("close_all", {28'h0, ctl.s_open}, 32'h0);
      cmd(CMD_MODE_LOAD, 2'h0, w);
      mode = w;
      for (int b = 0; b < 4; b++)
         if (open_e[b]) cmd(CMD_ROW_OPEN, 2'(b), row_of[b]);
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      cmd(CMD_NOP, 2'h0, 12'h0);
      chk("reset_open", {28'h0, ctl.s_open}, 32'h0);
      chk("reset_oe", {28'h0, ctl.s_oe}, 32'h0);
      open_row(2'h3, 12'hfff);
      wr(2'h3, 8'hff, 1'b0, 1, 32'hc0de0001, 4'h0);
      rd(2'h3, 8'hff, 1, 4'h0, 0, CMD_NOP, 2'h0);
      wr(2'h3, 8'hfe, 1'b1, 1, 32'hc0de0002, 4'h0);
      cmd(CMD_NOP, 2'h0, 12'h0);
      chk("auto_close", {28'h0, ctl.s_open}, 32'h0);
      open_row(2'h3, 12'hfff);
      $display("test corners done");
      open_row(2'h1, 12'h5a5);
      wr(2'h1, 8'h03, 1'b0, 1, 32'h11223344, 4'h0);
      wr(2'h1, 8'h03, 1'b0, 1, 32'haabbccdd, 4'h5);
      rd(2'h1, 8'h03, 1, 4'h0, 0, CMD_NOP, 2'h0);
      rd(2'h1, 8'h03, 1, 4'h9, 0, CMD_NOP, 2'h0);
      $display("test masks done");
      set_mode(12'h032);  // four words, sequential, latency three
      wr(2'h1, 8'h04, 1'b0, 4, 32'h40000000, 4'h0);
      rd(2'h1, 8'h05, 4, 4'h0, 0, CMD_NOP, 2'h0);
      set_mode(12'h02a);  // four words, interleaved, latency two
      rd(2'h1, 8'h05, 4, 4'h0, 0, CMD_NOP, 2'h0);
      set_mode(12'h023);  // eight words
      wr(2'h1, 8'h00, 1'b0, 8, 32'h80000000, 4'h0);
      rd(2'h1, 8'h06, 8, 4'h0, 0, CMD_NOP, 2'h0);
      set_mode(12'h021);  // two words
      rd(2'h1, 8'h05, 2, 4'h0, 0, CMD_NOP, 2'h0);
      set_mode(12'h027);  // full page, wraps until stopped
      wr(2'h1, 8'hfe, 1'b0, 4, 32'hf0000000, 4'h0);
      cmd(CMD_BURST_STOP, 2'h0, 12'h0);
      rd(2'h1, 8'hfe, 3, 4'h0, 3, CMD_BURST_STOP, 2'h0);
      $display("test bursts done");
      set_mode(12'h022);
      open_row(2'h0, 12'h001);
      rd(2'h1, 8'h04, 4, 4'h0, 2, CMD_CLOSE, 2'h0);
      open_e[0] = 1'b0;
      ctl.step({1'b1, CMD_CLOSE}, 2'h1, 12'h400, 4'h0, 32'h0, 1'b0);
      wr(2'h3, 8'h10, 1'b1, 4, 32'h30000000, 4'h0);
      open_e[3] = 1'b0;
      cmd(CMD_NOP, 2'h0, 12'h0);
      chk("open_banks", {28'h0, ctl.s_open}, {28'h0, open_e});
      $display("test banks done");
      cmd(CMD_CLOSE, 2'h0, 12'h400);
      repeat (CLOSE_WAIT) cmd(CMD_NOP, 2'h0, 12'h0);
      cmd(CMD_REFRESH, 2'h0, 12'h0);  // well inside the refresh interval
      ctl.set_cke(1'b0);
      cmd(CMD_NOP, 2'h0, 12'h0);
      cmd(CMD_ROW_OPEN, 2'h2, 12'h000);
      chk("power_down", {31'h0, ctl.s_pd}, 32'h1);
      ctl.set_cke(1'b1);
      repeat (3) cmd(CMD_NOP, 2'h0, 12'h0);
      chk("suspend_open", {28'h0, ctl.s_open}, 32'h0);
      chk("power_up", {31'h0, ctl.s_pd}, 32'h0);
      $display("test clock enable done");
      end_of_test();
   end
endmodule

`default_nettype wire
